/* verilog/window_watchdog_pkg.sv */
package window_watchdog_pkg;

	// Interval figures, all counted in oscillator cycles (one core_clk
	// cycle with clk_en high is one oscillator cycle).
	localparam int KICK_DEB_OSC        = 3;
	localparam int ROUSE_DEB_OSC       = 96;
	localparam int KICK_MAX_OSC        = 45;
	localparam int POWERUP_HOLD_OSC    = 201;
	localparam int SWITCHOVER_OSC      = 1112;
	localparam int SHORT_CLOSED_OSC    = 130;
	localparam int SHORT_OPEN_OSC      = 124;
	localparam int LONG_CLOSED_OSC     = 71970;
	localparam int LONG_OPEN_OSC       = 30002;
	localparam int RESET_PULSE_OSC     = 40;

	// Core clock cycles per oscillator cycle.
	localparam int CLK_PER_OSC         = 1;

	// Derived cycle counts.
	localparam int KICK_DEB_CYC        = KICK_DEB_OSC * CLK_PER_OSC;
	localparam int ROUSE_DEB_CYC       = ROUSE_DEB_OSC * CLK_PER_OSC;
	localparam int KICK_MAX_CYC        = KICK_MAX_OSC * CLK_PER_OSC;
	localparam int POWERUP_HOLD_CYC    = POWERUP_HOLD_OSC * CLK_PER_OSC;
	localparam int SWITCHOVER_CYC      = SWITCHOVER_OSC * CLK_PER_OSC;
	localparam int SHORT_CLOSED_CYC    = SHORT_CLOSED_OSC * CLK_PER_OSC;
	localparam int SHORT_OPEN_CYC      = SHORT_OPEN_OSC * CLK_PER_OSC;
	localparam int RESET_PULSE_CYC     = RESET_PULSE_OSC * CLK_PER_OSC;

	// Counter widths.
	localparam int TIMER_W             = 17;
	localparam int DEB_W               = 7;
	localparam int LOW_W               = 6;

	// Monitoring states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		ST_POWERUP      = 3'h0,
		ST_SWITCHOVER   = 3'h1,
		ST_SHORT_CLOSED = 3'h3,
		ST_SHORT_OPEN   = 3'h2,
		ST_LONG_CLOSED  = 3'h6,
		ST_LONG_OPEN    = 3'h7,
		ST_RESET_PULSE  = 3'h5
	} mon_state_t;

	// One debounced input with its stability counter.
	typedef struct packed {
		logic             level;
		logic             prev;
		logic [DEB_W-1:0] cnt;
	} deb_t;

	// Whole state of the watchdog core.
	typedef struct packed {
		mon_state_t         state;
		logic [TIMER_W-1:0] timer;
		deb_t               kick;
		deb_t               mode;
		deb_t               rouse;
		logic [LOW_W-1:0]   low_cnt;
		logic               reset_drive_n;
		logic               reset_level;
		logic               kick_fault;
		logic               long_mode;
	} core_t;

	localparam logic [DEB_W-1:0]   DEB_ZERO   = 7'h00;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 17'h00000;
	localparam logic [LOW_W-1:0]   LOW_ZERO   = 6'h00;

endpackage

/* verilog/window_watchdog_timing.sv */
`timescale 1ns/1ps
`default_nettype none

module window_watchdog_timing #(
	parameter int LONG_CLOSED_CYCLES = window_watchdog_pkg::LONG_CLOSED_OSC,
	parameter int LONG_OPEN_CYCLES   = window_watchdog_pkg::LONG_OPEN_OSC
) (
	// Clock, reset and oscillator enable
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic clk_en,
	// Controller-side inputs
	input  wire logic kick_input,
	input  wire logic window_select,
	input  wire logic rouse_pin,
	// Open-drain reset pin and status
	output var  logic reset_pin_o,
	output var  logic reset_pin_oe_n,
	output var  logic kick_fault,
	output var  logic long_mode
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// True when the timer sits on the last cycle of an n-cycle interval.
	function automatic logic last_cycle(
		input logic [window_watchdog_pkg::TIMER_W-1:0] t,
		input int                                      n);
		last_cycle = (t == n[window_watchdog_pkg::TIMER_W-1:0] - 17'h00001);
	endfunction

	// Debounce step: a level differing from the held one for n cycles wins.
	function automatic window_watchdog_pkg::deb_t deb_step(
		input window_watchdog_pkg::deb_t d,
		input logic                      raw,
		input int                        n);
		deb_step = d;
		deb_step.prev = d.level;
		if (raw == d.level) begin
			deb_step.cnt = window_watchdog_pkg::DEB_ZERO;
		end else if (d.cnt == n[window_watchdog_pkg::DEB_W-1:0] - 7'h01) begin
			deb_step.level = raw;
			deb_step.cnt = window_watchdog_pkg::DEB_ZERO;
		end else begin
			deb_step.cnt = d.cnt + 7'h01;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State and next state.

	window_watchdog_pkg::core_t core_reg;
	window_watchdog_pkg::core_t core_next;
	logic                       kick_ok;
	logic                       kick_err;
	logic                       rouse_edge;
	logic                       mode_long;

	// Event decode from the debounced levels held in the state.
	assign kick_ok    = core_reg.kick.level && !core_reg.kick.prev;
	assign rouse_edge = core_reg.rouse.level != core_reg.rouse.prev;
	assign mode_long  = core_reg.mode.level;
	assign kick_err   = !core_reg.kick.level &&
		(core_reg.low_cnt == window_watchdog_pkg::KICK_MAX_CYC[5:0]);

	// Next state; faults take priority over a window-select change so a
	// misbehaving controller cannot dodge a reset by toggling the select.
	always_comb begin
		core_next = core_reg;
		core_next.kick  = deb_step(core_reg.kick, kick_input,
			window_watchdog_pkg::KICK_DEB_CYC);
		core_next.mode  = deb_step(core_reg.mode, window_select,
			window_watchdog_pkg::KICK_DEB_CYC);
		core_next.rouse = deb_step(core_reg.rouse, rouse_pin,
			window_watchdog_pkg::ROUSE_DEB_CYC);
		// Low-time counter saturates one past the limit, so the error
		// fires once per overlong pulse; the controller must stay within it.
		if (core_reg.kick.level) begin
			core_next.low_cnt = window_watchdog_pkg::LOW_ZERO;
		end else if (core_reg.low_cnt !=
			window_watchdog_pkg::KICK_MAX_CYC[5:0] + 6'h01) begin
			core_next.low_cnt = core_reg.low_cnt + 6'h01;
		end
		core_next.timer = core_reg.timer + 17'h00001;
		case (core_reg.state)
			window_watchdog_pkg::ST_POWERUP: begin
				if (last_cycle(core_reg.timer,
					window_watchdog_pkg::POWERUP_HOLD_CYC)) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end
			end
			window_watchdog_pkg::ST_SWITCHOVER: begin
				if (last_cycle(core_reg.timer,
					window_watchdog_pkg::SWITCHOVER_CYC)) begin
					core_next.state = mode_long ?
						window_watchdog_pkg::ST_LONG_CLOSED :
						window_watchdog_pkg::ST_SHORT_CLOSED;
				end
			end
			window_watchdog_pkg::ST_SHORT_CLOSED: begin
				if (kick_ok || kick_err) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (mode_long) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end else if (last_cycle(core_reg.timer,
					window_watchdog_pkg::SHORT_CLOSED_CYC)) begin
					core_next.state = window_watchdog_pkg::ST_SHORT_OPEN;
				end
			end
			window_watchdog_pkg::ST_SHORT_OPEN: begin
				if (kick_err) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (kick_ok) begin
					core_next.state = window_watchdog_pkg::ST_SHORT_CLOSED;
				end else if (last_cycle(core_reg.timer,
					window_watchdog_pkg::SHORT_OPEN_CYC)) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (mode_long) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end
			end
			window_watchdog_pkg::ST_LONG_CLOSED: begin
				if (rouse_edge || kick_ok || kick_err) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (!mode_long) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end else if (last_cycle(core_reg.timer,
					LONG_CLOSED_CYCLES)) begin
					core_next.state = window_watchdog_pkg::ST_LONG_OPEN;
				end
			end
			window_watchdog_pkg::ST_LONG_OPEN: begin
				if (rouse_edge || kick_err) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (kick_ok) begin
					core_next.state = window_watchdog_pkg::ST_LONG_CLOSED;
				end else if (last_cycle(core_reg.timer, LONG_OPEN_CYCLES)) begin
					core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
				end else if (!mode_long) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end
			end
			window_watchdog_pkg::ST_RESET_PULSE: begin
				if (last_cycle(core_reg.timer,
					window_watchdog_pkg::RESET_PULSE_CYC)) begin
					core_next.state = window_watchdog_pkg::ST_SWITCHOVER;
				end
			end
			default: begin
				core_next.state = window_watchdog_pkg::ST_RESET_PULSE;
			end
		endcase
		// Any state change restarts the interval timer.
		if (core_next.state != core_reg.state) begin
			core_next.timer = window_watchdog_pkg::TIMER_ZERO;
		end
		// Pin pulled low in the hold and pulse states only.
		core_next.reset_drive_n =
			!(core_next.state == window_watchdog_pkg::ST_POWERUP ||
			core_next.state == window_watchdog_pkg::ST_RESET_PULSE);
		core_next.reset_level = 1'b0;
		core_next.kick_fault = kick_err ||
			(core_next.state == window_watchdog_pkg::ST_RESET_PULSE &&
			core_reg.state != window_watchdog_pkg::ST_RESET_PULSE &&
			!(rouse_edge && core_reg.long_mode));
		core_next.long_mode =
			core_next.state == window_watchdog_pkg::ST_LONG_CLOSED ||
			core_next.state == window_watchdog_pkg::ST_LONG_OPEN;
	end

	// State register; clk_en low freezes everything, which is how a
	// slower oscillator rate is modelled without a second clock domain.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			core_reg <= '{state: window_watchdog_pkg::ST_POWERUP,
				timer: window_watchdog_pkg::TIMER_ZERO,
				kick: '{1'b1, 1'b1, window_watchdog_pkg::DEB_ZERO},
				mode: '{1'b1, 1'b1, window_watchdog_pkg::DEB_ZERO},
				rouse: '{1'b0, 1'b0, window_watchdog_pkg::DEB_ZERO},
				low_cnt: window_watchdog_pkg::LOW_ZERO,
				reset_drive_n: 1'b0,
				reset_level: 1'b0,
				kick_fault: 1'b0,
				long_mode: 1'b0};
		end else if (clk_en) begin
			core_reg <= core_next;
		end
	end

	// Outputs straight from the state register.
	assign reset_pin_o    = core_reg.reset_level;
	assign reset_pin_oe_n = core_reg.reset_drive_n;
	assign kick_fault     = core_reg.kick_fault;
	assign long_mode      = core_reg.long_mode;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn || !clk_en);

	kick_debounce_a: assert property (
		($stable(kick_input))[*4] |-> core_reg.kick.level == kick_input)
		else $error("kick level not taken after debounce");
	rouse_debounce_a: assert property (
		$changed(core_reg.rouse.level) |->
			$past(rouse_pin, 96) == core_reg.rouse.level)
		else $error("rouse level taken too early");
	powerup_hold_a: assert property (
		core_reg.state == window_watchdog_pkg::ST_POWERUP &&
		core_reg.timer == 17'h000c8 |=>
			core_reg.state == window_watchdog_pkg::ST_SWITCHOVER ##1
			reset_pin_oe_n)
		else $error("power-up hold length wrong");
	pulse_width_a: assert property (
		$fell(reset_pin_oe_n) && core_reg.state ==
			window_watchdog_pkg::ST_RESET_PULSE |->
			(!reset_pin_oe_n)[*8] ##32 !reset_pin_oe_n ##1 reset_pin_oe_n)
		else $error("reset pulse width wrong");
	closed_kick_a: assert property (
		core_reg.state == window_watchdog_pkg::ST_SHORT_CLOSED && kick_ok
			|=> core_reg.state == window_watchdog_pkg::ST_RESET_PULSE &&
			!reset_pin_oe_n && kick_fault)
		else $error("kick in closed window not punished");
	open_timeout_a: assert property (
		core_reg.state == window_watchdog_pkg::ST_SHORT_OPEN &&
		core_reg.timer == 17'h0007b && !kick_ok && !kick_err |=>
			core_reg.state == window_watchdog_pkg::ST_RESET_PULSE)
		else $error("short open window length wrong");
	switch_mode_a: assert property (
		core_reg.state == window_watchdog_pkg::ST_SWITCHOVER &&
		core_reg.timer == 17'h00457 |=>
			long_mode == $past(core_reg.mode.level))
		else $error("switch-over did not follow select");
	rouse_wake_a: assert property (
		long_mode && rouse_edge |=> !reset_pin_oe_n)
		else $error("rouse edge in long mode ignored");
	timer_restart_a: assert property (
		core_reg.state != $past(core_reg.state) |->
			core_reg.timer == window_watchdog_pkg::TIMER_ZERO)
		else $error("timer not restarted on state change");
	low_kick_a: assert property (
		$fell(core_reg.kick.level) ##1 (!core_reg.kick.level)[*8]
			##1 (!core_reg.kick.level)[*8] ##1 (!core_reg.kick.level)[*8]
			##1 (!core_reg.kick.level)[*8] ##1 (!core_reg.kick.level)[*8]
			##1 (!core_reg.kick.level)[*5] |-> kick_err)
		else $error("overlong kick not flagged");

	good_kick_c: cover property (
		core_reg.state == window_watchdog_pkg::ST_SHORT_OPEN && kick_ok);
	enter_long_c: cover property (
		core_reg.state == window_watchdog_pkg::ST_LONG_CLOSED);
	rouse_c: cover property (long_mode && rouse_edge);
	kick_err_c: cover property (kick_err);

endmodule

`default_nettype wire

/* test/mcu_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module mcu_partner (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Commands from the bench
	input  wire logic       kick_go,
	input  wire logic [6:0] kick_len,
	// Watchdog side
	input  wire logic       reset_pin_oe_n,
	output var  logic       kick_input,
	output var  logic       kick_busy
);

	logic [6:0] low_left_reg;

	////////////////////////////////////////////////////////////////////////
	// Low phase of a kick; a controller held in reset cannot finish one.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			low_left_reg <= 7'h00;
		end else if (!reset_pin_oe_n) begin
			low_left_reg <= 7'h00;
		end else if (kick_go) begin
			low_left_reg <= kick_len;
		end else if (low_left_reg != 7'h00) begin
			low_left_reg <= low_left_reg - 7'h01;
		end
	end

	// The kick line idles high and is low while the count runs.
	assign kick_input = (low_left_reg == 7'h00);
	assign kick_busy  = (low_left_reg != 7'h00);

endmodule

`default_nettype wire

/* test/window_watchdog_timing_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module window_watchdog_timing_bench;

	logic       core_clk;
	logic       resetn;
	logic       clk_en;
	logic       window_select;
	logic       rouse_pin;
	logic       kick_go;
	logic [6:0] kick_len;
	logic       kick_input;
	logic       kick_busy;
	logic       reset_pin_o;
	logic       reset_pin_oe_n;
	logic       kick_fault;
	logic       long_mode;
	logic       fault_seen;
	logic       rst_seen;
	int         fail_count;
	int         num_checks;
	int         cyc;
	int         n;

	// Long windows are shortened to 300 and 200 to keep the run brief.
	window_watchdog_timing #(
		.LONG_CLOSED_CYCLES(300),
		.LONG_OPEN_CYCLES  (200)
	) u_window_watchdog_timing (
		.core_clk      (core_clk),
		.resetn        (resetn),
		.clk_en        (clk_en),
		.kick_input    (kick_input),
		.window_select (window_select),
		.rouse_pin     (rouse_pin),
		.reset_pin_o   (reset_pin_o),
		.reset_pin_oe_n(reset_pin_oe_n),
		.kick_fault    (kick_fault),
		.long_mode     (long_mode)
	);

	mcu_partner u_mcu_partner (
		.core_clk      (core_clk),
		.resetn        (resetn),
		.kick_go       (kick_go),
		.kick_len      (kick_len),
		.reset_pin_oe_n(reset_pin_oe_n),
		.kick_input    (kick_input),
		.kick_busy     (kick_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// Free running clock of 5 ns.
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	// Sticky flags and a hang guard, sampled where outputs have settled.
	always @(negedge core_clk) begin
		cyc++;
		if (kick_fault === 1'b1) fault_seen = 1'b1;
		if (reset_pin_oe_n === 1'b0) rst_seen = 1'b1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wait_cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	// Counts negedges while the reset enable stays at one level.
	task automatic run_len(input logic lvl, output int k);
		k = 0;
		while (reset_pin_oe_n === lvl && k < 5000) begin
			k++;
			@(negedge core_clk);
		end
	endtask

	// Returns on the negedge after the kick line is high again.
	task automatic kick(input logic [6:0] len);
		@(posedge core_clk);
		kick_go  <= 1'b1;
		kick_len <= len;
		@(posedge core_clk);
		kick_go <= 1'b0;
		@(negedge core_clk);
		while (kick_busy) @(negedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_powerup();
		run_len(1'b0, n);
		check("powerup hold", n, 201);
		run_len(1'b1, n);
		check("short cycle", n, 1112 + 130 + 124);
		run_len(1'b0, n);
		check("reset width", n, 40);
		check("window fault", fault_seen, 1'b1);
		$display("test powerup done");
	endtask

	// Glitch and kick in time, then a kick inside the closed window.
	task automatic t_kick();
		fault_seen = 1'b0;
		rst_seen   = 1'b0;
		wait_cyc(1122);
		kick(7'h02);
		wait_cyc(173);
		kick(7'h0a);
		wait_cyc(80);
		check("good kick reset", rst_seen, 1'b0);
		check("good kick fault", fault_seen, 1'b0);
		kick(7'h0a);
		wait_cyc(10);
		check("early kick reset", rst_seen, 1'b1);
		check("early kick fault", fault_seen, 1'b1);
		run_len(1'b0, n);
		$display("test kick done");
	endtask

	// Long windows, a rouse edge, then back to short windows.
	task automatic t_long();
		@(posedge core_clk);
		window_select <= 1'b1;
		n = 0;
		while (long_mode !== 1'b1 && n < 3000) begin
			n++;
			@(negedge core_clk);
		end
		check("long entry", n >= 1100 && n <= 1120, 1'b1);
		run_len(1'b1, n);
		check("long cycle", n >= 495 && n <= 505, 1'b1);
		run_len(1'b0, n);
		while (long_mode !== 1'b1 && n < 3000) begin
			n++;
			@(negedge core_clk);
		end
		wait_cyc(10);
		fault_seen = 1'b0;
		@(posedge core_clk);
		rouse_pin <= ~rouse_pin;
		@(negedge core_clk);
		run_len(1'b1, n);
		check("rouse delay", n >= 95 && n <= 135, 1'b1);
		@(posedge core_clk);
		window_select <= 1'b0;
		@(negedge core_clk);
		run_len(1'b0, n);
		// One low negedge passed before the select drop was driven.
		check("rouse width", n + 1, 40);
		check("rouse fault", fault_seen, 1'b0);
		run_len(1'b1, n);
		check("short again", n >= 1360 && n <= 1375, 1'b1);
		run_len(1'b0, n);
		$display("test long done");
	endtask

	// Kick held low too long while no window is open.
	task automatic t_long_kick();
		fault_seen = 1'b0;
		rst_seen   = 1'b0;
		kick(7'h32);
		wait_cyc(5);
		check("kick error", fault_seen, 1'b1);
		check("kick error reset", rst_seen, 1'b0);
		$display("test long kick done");
	endtask

	// Mid-run reset, then a clock-enable freeze inside the power-up hold.
	task automatic t_freeze();
		@(posedge core_clk);
		resetn <= 1'b0;
		@(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		check("reset enable", reset_pin_oe_n, 1'b0);
		check("reset data", reset_pin_o, 1'b0);
		check("reset mode", long_mode, 1'b0);
		wait_cyc(100);
		@(posedge core_clk);
		clk_en <= 1'b0;
		repeat (50) @(posedge core_clk);
		clk_en <= 1'b1;
		@(negedge core_clk);
		// 101 enabled edges passed; the 50 frozen ones must not count.
		run_len(1'b0, n);
		check("frozen hold", n, 201 - 101);
		$display("test freeze done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset for three cycles, then run the scenarios in order.
	initial begin
		resetn        = 1'b0;
		clk_en        = 1'b1;
		window_select = 1'b0;
		rouse_pin     = 1'b0;
		kick_go       = 1'b0;
		kick_len      = 7'h00;
		fail_count    = 0;
		num_checks    = 0;
		cyc           = 0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		t_powerup();
		t_kick();
		t_long();
		t_long_kick();
		t_freeze();
		finish_test();
	end

endmodule

`default_nettype wire
